// file: sws_params.svh
// constants of the subtract datapath: opcodes, field positions, offsets, reset values
`ifndef SWS_PARAMS_SVH
`define SWS_PARAMS_SVH

// instruction encoding
`define SWS_OPC_LIT 8'h08
`define SWS_OPC_REG 6'h17
`define SWS_DEST_BIT 9
`define SWS_ACCESS_BIT 8

// access bank split: low half maps to bank 0, high half to the top bank
`define SWS_ACCESS_SPLIT 8'h80
`define SWS_BANK_ACCESS_LO 4'h0
`define SWS_BANK_ACCESS_HI 4'hf

// one instruction cycle is four clock phases
`define SWS_PHASES_PER_CYCLE 4

// register port offsets
`define SWS_REG_ACC 4'h0
`define SWS_REG_BANK 4'h1
`define SWS_REG_STATUS 4'h2
`define SWS_REG_RESULT 4'h3
`define SWS_REG_ADDR_LO 4'h4
`define SWS_REG_ADDR_HI 4'h5
`define SWS_REG_STATE 4'h6
`define SWS_REG_ILLEGAL 4'h7

// reset values
`define SWS_ACC_RST 8'h00
`define SWS_BANK_RST 4'h0
`define SWS_STATUS_RST 5'h00
`define SWS_ADDR_RST 12'h000
`define SWS_COUNT_RST 8'h00

`endif

// file: sws_pkg.sv
// types shared by the subtract datapath modules
`default_nettype none
package sws_pkg;

    typedef enum logic [2:0] {
        SWS_PH_IDLE = 3'b000,
        SWS_PH_Q1 = 3'b001,
        SWS_PH_Q2 = 3'b011,
        SWS_PH_Q3 = 3'b010,
        SWS_PH_Q4 = 3'b110
    } sws_phase_e;

    typedef enum logic [1:0] {
        SWS_OP_NONE = 2'b00,
        SWS_OP_LIT = 2'b01,
        SWS_OP_REG = 2'b11
    } sws_op_e;

    // bit order matches the status register, n in bit 4 down to carry in bit 0
    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } sws_flags_s;

    typedef struct packed {
        sws_op_e op;
        logic to_reg;
        logic banked;
        logic [7:0] operand;
    } sws_dec_s;

endpackage
`default_nettype wire

// file: sws_subtractor.sv
// 8-bit subtractor with negative, overflow, carry, digit-carry and zero flags
`default_nettype none
module sws_subtractor (
    input wire logic [7:0] minuend,
    input wire logic [7:0] subtrahend,
    output logic [7:0] diff,
    output sws_pkg::sws_flags_s flags
);
    logic [8:0] wide;
    logic [4:0] low;

    always_comb begin
        // ninth bit is the borrow; carry is its inverse
        wide = {1'b0, minuend} - {1'b0, subtrahend};
        low = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
        diff = wide[7:0]; // RL13
        flags.c = ~wide[8]; // RL10 RL11 RL12
        flags.dc = ~low[4]; // RL14
        flags.ov = (minuend[7] ^ subtrahend[7]) & (wide[7] ^ minuend[7]); // RL14
        flags.z = (wide[7:0] == 8'h00); // RL11
        flags.n = wide[7]; // RL12
    end
endmodule
`default_nettype wire

// file: sws_phase_seq.sv
// four-phase instruction cycle sequencer
`default_nettype none
module sws_phase_seq (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic start,
    output sws_pkg::sws_phase_e phase,
    output logic ready
);
    sws_pkg::sws_phase_e phase_ff;
    sws_pkg::sws_phase_e nxt_phase;

    always_comb begin
        nxt_phase = phase_ff;
        case (phase_ff)
            sws_pkg::SWS_PH_IDLE: begin
                if (start) begin
                    nxt_phase = sws_pkg::SWS_PH_Q1;
                end
            end
            sws_pkg::SWS_PH_Q1: nxt_phase = sws_pkg::SWS_PH_Q2;
            sws_pkg::SWS_PH_Q2: nxt_phase = sws_pkg::SWS_PH_Q3;
            sws_pkg::SWS_PH_Q3: nxt_phase = sws_pkg::SWS_PH_Q4;
            sws_pkg::SWS_PH_Q4: begin
                // back to back instructions skip the idle state
                if (start) begin
                    nxt_phase = sws_pkg::SWS_PH_Q1;
                end else begin
                    nxt_phase = sws_pkg::SWS_PH_IDLE;
                end
            end
            default: nxt_phase = sws_pkg::SWS_PH_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            phase_ff <= sws_pkg::SWS_PH_IDLE;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    assign phase = phase_ff;
    assign ready = (phase_ff == sws_pkg::SWS_PH_IDLE) || (phase_ff == sws_pkg::SWS_PH_Q4);
endmodule
`default_nettype wire

// file: sws_datapath.sv
// subtract datapath top: decode, operand fetch, subtract, write back and register port
// Contract
// RL1 - literal minus accumulator goes to accumulator
// RL2 - decode literal form from fixed upper byte
// RL3 - both forms update n, ov, c, dc, z
// RL4 - literal form: decode, read, process, write
// RL5 - register form: register minus accumulator
// RL6 - destination bit 0 accumulator, 1 register
// RL7 - access bit 0 selects access bank
// RL8 - access bit 1 uses bank select register
// RL9 - register form: decode, read, process, write
// RL10 - positive result: carry set, z n clear
// RL11 - zero result: carry set, z set
// RL12 - borrow: carry clear, n set, z clear
// RL13 - negative result wraps to eight bits
// RL14 - digit carry and overflow usual definitions
//
// Implementation choices: the strobed register port and the placing of the registers.
`include "sws_params.svh"
`default_nettype none
module sws_datapath (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    output logic instr_ready,
    output logic instr_done,
    output logic instr_illegal,
    output logic [11:0] mem_addr,
    output logic mem_rd,
    input wire logic [7:0] mem_rdata,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic [7:0] acc_out,
    output sws_pkg::sws_flags_s flags_out
);
    sws_pkg::sws_phase_e phase;
    logic seq_ready;
    logic accept;
    logic start;
    sws_pkg::sws_dec_s dec_in;
    logic [7:0] minuend;
    logic [7:0] diff;
    sws_pkg::sws_flags_s diff_flags;
    logic to_mem;

    // datapath state
    sws_pkg::sws_dec_s dec_ff;
    sws_pkg::sws_dec_s nxt_dec;
    logic [7:0] acc_ff;
    logic [7:0] nxt_acc;
    logic [3:0] bank_select_register_ff;
    logic [3:0] nxt_bank_select_register;
    sws_pkg::sws_flags_s status_ff;
    sws_pkg::sws_flags_s nxt_status;
    sws_pkg::sws_flags_s pend_flags_ff;
    sws_pkg::sws_flags_s nxt_pend_flags;
    logic [7:0] result_ff;
    logic [7:0] nxt_result;
    logic [11:0] mem_addr_ff;
    logic [11:0] nxt_mem_addr;
    logic mem_rd_ff;
    logic nxt_mem_rd;
    logic mem_wr_ff;
    logic nxt_mem_wr;
    logic [7:0] mem_wdata_ff;
    logic [7:0] nxt_mem_wdata;
    logic done_ff;
    logic nxt_done;
    logic illegal_ff;
    logic nxt_illegal;
    logic [7:0] illegal_count_ff;
    logic [7:0] nxt_illegal_count;

    // register port read state
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    function automatic sws_pkg::sws_dec_s decode(input logic [15:0] w);
        sws_pkg::sws_dec_s d;
        d.op = sws_pkg::SWS_OP_NONE;
        d.to_reg = 1'b0;
        d.banked = 1'b0;
        d.operand = w[7:0];
        if (w[15:8] == `SWS_OPC_LIT) begin // RL2
            d.op = sws_pkg::SWS_OP_LIT;
        end else if (w[15:10] == `SWS_OPC_REG) begin
            d.op = sws_pkg::SWS_OP_REG;
            d.to_reg = w[`SWS_DEST_BIT];
            d.banked = w[`SWS_ACCESS_BIT];
        end
        return d;
    endfunction

    // the access bank is the low half of bank 0 joined to the high half of the top bank
    function automatic logic [11:0] eff_addr(input logic banked, input logic [7:0] f,
                                              input logic [3:0] bank);
        logic [11:0] a;
        if (banked) begin
            a = {bank, f}; // RL8
        end else if (f >= `SWS_ACCESS_SPLIT) begin
            a = {`SWS_BANK_ACCESS_HI, f}; // RL7
        end else begin
            a = {`SWS_BANK_ACCESS_LO, f}; // RL7
        end
        return a;
    endfunction

    assign dec_in = decode(instr_word);
    assign accept = instr_valid & seq_ready;
    assign start = accept & (dec_in.op != sws_pkg::SWS_OP_NONE);
    assign to_mem = (dec_ff.op == sws_pkg::SWS_OP_REG) & dec_ff.to_reg;

    sws_phase_seq u_seq (
        .sys_clk(sys_clk),
        .srst(srst),
        .start(start),
        .phase(phase),
        .ready(seq_ready)
    );

    // the literal form takes its minuend from the word, the register form from memory
    assign minuend = (dec_ff.op == sws_pkg::SWS_OP_LIT) ? dec_ff.operand : mem_rdata; // RL1 RL5

    sws_subtractor u_sub (
        .minuend(minuend),
        .subtrahend(acc_ff),
        .diff(diff),
        .flags(diff_flags)
    );

    // instruction group: capture, operand fetch, subtract and memory write back
    always_comb begin
        nxt_dec = dec_ff;
        nxt_pend_flags = pend_flags_ff;
        nxt_result = result_ff;
        nxt_mem_addr = mem_addr_ff;
        nxt_mem_rd = 1'b0;
        nxt_mem_wr = 1'b0;
        nxt_mem_wdata = mem_wdata_ff;
        nxt_done = 1'b0;

        if (start) begin
            nxt_dec = dec_in;
        end

        case (phase)
            sws_pkg::SWS_PH_Q1: begin
                // decode: form the data address, read strobe lands in the read phase
                if (dec_ff.op == sws_pkg::SWS_OP_REG) begin // RL9
                    nxt_mem_addr = eff_addr(dec_ff.banked, dec_ff.operand,
                                            bank_select_register_ff);
                    nxt_mem_rd = 1'b1;
                end
            end
            sws_pkg::SWS_PH_Q2: begin
                // read: memory answers at the coming edge, nothing to latch yet
                nxt_mem_rd = 1'b0;
            end
            sws_pkg::SWS_PH_Q3: begin
                // process: memory data is valid in this phase, one cycle after the strobe
                nxt_result = diff; // RL13
                nxt_pend_flags = diff_flags; // RL3
                nxt_done = 1'b1;
                if (to_mem) begin // RL6
                    nxt_mem_wr = 1'b1;
                    nxt_mem_wdata = diff;
                end
            end
            default: begin
                nxt_mem_rd = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            dec_ff <= '0;
            pend_flags_ff <= `SWS_STATUS_RST;
            result_ff <= `SWS_ACC_RST;
            mem_addr_ff <= `SWS_ADDR_RST;
            mem_rd_ff <= 1'b0;
            mem_wr_ff <= 1'b0;
            mem_wdata_ff <= `SWS_ACC_RST;
            done_ff <= 1'b0;
        end else begin
            dec_ff <= nxt_dec;
            pend_flags_ff <= nxt_pend_flags;
            result_ff <= nxt_result;
            mem_addr_ff <= nxt_mem_addr;
            mem_rd_ff <= nxt_mem_rd;
            mem_wr_ff <= nxt_mem_wr;
            mem_wdata_ff <= nxt_mem_wdata;
            done_ff <= nxt_done;
        end
    end

    // software-visible group: accumulator, bank select and status
    always_comb begin
        nxt_acc = acc_ff;
        nxt_bank_select_register = bank_select_register_ff;
        nxt_status = status_ff;
        // software writes first, so a commit in the same cycle overrides them
        if (reg_wr) begin
            if (reg_addr == `SWS_REG_ACC) begin
                nxt_acc = reg_wdata;
            end else if (reg_addr == `SWS_REG_BANK) begin
                nxt_bank_select_register = reg_wdata[3:0];
            end else if (reg_addr == `SWS_REG_STATUS) begin
                nxt_status = sws_pkg::sws_flags_s'(reg_wdata[4:0]);
            end
        end

        if (phase == sws_pkg::SWS_PH_Q4) begin
            // write: flags, and the accumulator when it is the destination, change at the end of the cycle
            if (!to_mem) begin // RL1 RL4 RL6
                nxt_acc = result_ff;
            end
            nxt_status = pend_flags_ff; // RL3 RL10 RL11 RL12 RL14
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            acc_ff <= `SWS_ACC_RST;
            bank_select_register_ff <= `SWS_BANK_RST;
            status_ff <= `SWS_STATUS_RST;
        end else begin
            acc_ff <= nxt_acc;
            bank_select_register_ff <= nxt_bank_select_register;
            status_ff <= nxt_status;
        end
    end

    // illegal words: a one-cycle flag and a saturating count
    always_comb begin
        nxt_illegal = accept & (dec_in.op == sws_pkg::SWS_OP_NONE);
        nxt_illegal_count = illegal_count_ff;
        if (reg_wr && (reg_addr == `SWS_REG_ILLEGAL)) begin
            nxt_illegal_count = `SWS_COUNT_RST;
        end
        // counting wins over a clear in the same cycle; saturates at the top
        if (nxt_illegal && (illegal_count_ff != 8'hff)) begin
            nxt_illegal_count = illegal_count_ff + 8'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            illegal_ff <= 1'b0;
            illegal_count_ff <= `SWS_COUNT_RST;
        end else begin
            illegal_ff <= nxt_illegal;
            illegal_count_ff <= nxt_illegal_count;
        end
    end

    // read data stands for the one cycle after the strobe, zero otherwise
    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_rd) begin
            if (reg_addr == `SWS_REG_ACC) begin
                nxt_rdata = acc_ff;
            end else if (reg_addr == `SWS_REG_BANK) begin
                nxt_rdata = {4'h0, bank_select_register_ff};
            end else if (reg_addr == `SWS_REG_STATUS) begin
                nxt_rdata = {3'h0, status_ff};
            end else if (reg_addr == `SWS_REG_RESULT) begin
                nxt_rdata = result_ff;
            end else if (reg_addr == `SWS_REG_ADDR_LO) begin
                nxt_rdata = mem_addr_ff[7:0];
            end else if (reg_addr == `SWS_REG_ADDR_HI) begin
                nxt_rdata = {4'h0, mem_addr_ff[11:8]};
            end else if (reg_addr == `SWS_REG_STATE) begin
                nxt_rdata = {5'h00, phase};
            end else if (reg_addr == `SWS_REG_ILLEGAL) begin
                nxt_rdata = illegal_count_ff;
            end else begin
                nxt_rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign instr_ready = seq_ready;
    assign instr_done = done_ff;
    assign instr_illegal = illegal_ff;
    assign mem_addr = mem_addr_ff;
    assign mem_rd = mem_rd_ff;
    assign mem_wr = mem_wr_ff;
    assign mem_wdata = mem_wdata_ff;
    assign reg_rdata = rdata_ff;
    assign acc_out = acc_ff;
    assign flags_out = status_ff;
endmodule
`default_nettype wire

// file: sws_datapath_checker.sv
// concurrent checks on the subtract datapath ports
`include "sws_params.svh"
`default_nettype none
module sws_datapath_checker (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    input wire logic instr_ready,
    input wire logic instr_done,
    input wire logic instr_illegal,
    input wire logic [11:0] mem_addr,
    input wire logic mem_rd,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] acc_out,
    input wire sws_pkg::sws_flags_s flags_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic take;
    logic lit;
    logic regf;
    assign take = instr_valid && instr_ready;
    assign lit = take && instr_word[15:8] == `SWS_OPC_LIT;
    assign regf = take && instr_word[15:10] == `SWS_OPC_REG;
    // subtrahend is the accumulator as seen in the process phase
    AST_LIT_RESULT: assert property (lit |-> ##5
        acc_out == $past(instr_word[7:0], 5) - $past(acc_out, 2))
        else $error("literal result wrong");
    AST_LIT_FLAGS: assert property (lit |-> ##5
        flags_out.c == ($past(instr_word[7:0], 5) >= $past(acc_out, 2))
        && flags_out.z == (acc_out == 8'h00) && flags_out.n == acc_out[7])
        else $error("literal flags wrong");
    AST_REG_WDATA: assert property (regf && instr_word[`SWS_DEST_BIT] |-> ##4
        mem_wr && mem_wdata == $past(mem_rdata) - $past(acc_out))
        else $error("register write back wrong");
    AST_REG_TO_ACC: assert property (regf && !instr_word[`SWS_DEST_BIT] |-> ##4
        !mem_wr ##1 acc_out == $past(mem_rdata, 2) - $past(acc_out, 2))
        else $error("accumulator destination wrong");
    AST_READ_STROBE: assert property (regf |-> ##2
        mem_rd && mem_addr[7:0] == $past(instr_word[7:0], 2))
        else $error("register read missing");
    AST_ACCESS: assert property (regf && !instr_word[`SWS_ACCESS_BIT] |-> ##2
        mem_addr[11:8] == ($past(instr_word[7], 2) ? 4'hf : 4'h0))
        else $error("access bank wrong");
    AST_CYCLE: assert property ((lit || regf) |-> ##1 !instr_ready [*3]
        ##1 instr_ready && instr_done)
        else $error("four phase cycle broken");
    AST_ILLEGAL: assert property (take && !lit && !regf |=>
        instr_illegal && !instr_done)
        else $error("illegal word not flagged");
    AST_RDATA: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
endmodule
bind sws_datapath sws_datapath_checker u_chk (.sys_clk, .srst, .instr_word, .instr_valid,
    .instr_ready, .instr_done, .instr_illegal, .mem_addr, .mem_rd, .mem_rdata, .mem_wr,
    .mem_wdata, .reg_rd, .reg_rdata, .acc_out, .flags_out);
`default_nettype wire

// file: tb.sv
// self-checking bench for the subtract datapath
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [15:0] instr_word = 16'h0000;
    logic instr_valid = 1'b0;
    logic instr_ready, instr_done, instr_illegal, mem_rd, mem_wr;
    logic [11:0] mem_addr;
    logic [7:0] mem_rdata = 8'h00;
    logic [7:0] mem_wdata, reg_rdata, acc_out;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    sws_pkg::sws_flags_s flags_out;
    logic [7:0] mem [0:4095];
    int mismatches = 0;
    int checked = 0;
    logic [7:0] tm [5] = '{8'h02, 8'h02, 8'h02, 8'h80, 8'h7f};
    logic [7:0] ts [5] = '{8'h01, 8'h02, 8'h03, 8'h01, 8'hff};
    logic [7:0] tf [5] = '{8'h10, 8'h90, 8'h20, 8'ha5, 8'h80};
    sws_datapath dut (.sys_clk, .srst, .instr_word, .instr_valid, .instr_ready, .instr_done,
        .instr_illegal, .mem_addr, .mem_rd, .mem_rdata, .mem_wr, .mem_wdata, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .acc_out, .flags_out);
    always #5 sys_clk = ~sys_clk;
    // data memory; read data toggles outside its valid cycle so stale data cannot pass
    always @(posedge sys_clk) begin
        mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
        if (mem_wr) mem[mem_addr] <= mem_wdata;
    end
    task end_sim;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function logic [4:0] fl(input logic [7:0] m, input logic [7:0] s);
        logic [7:0] d;
        d = m - s;
        fl = {d[7], m[7] != s[7] && d[7] != m[7], d == 8'h00, m[3:0] >= s[3:0], m >= s};
    endfunction
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", 12'(reg_rdata), 12'(e));
    endtask
    task issue(input logic [15:0] w);
        int i;
        logic ok;
        ok = 1'b0;
        @(posedge sys_clk);
        instr_word <= w;
        instr_valid <= 1'b1;
        for (i = 0; i < 20 && !ok; i++) begin
            #1 ok = (instr_ready === 1'b1);
            @(posedge sys_clk);
        end
        instr_valid <= 1'b0;
        if (!ok) begin
            mismatches++;
            end_sim;
        end
    endtask
    // one subtract in either form; r picks the register form
    task run(input logic r, input logic [7:0] m, s, f, input logic d, a);
        logic [11:0] ad;
        logic [7:0] e;
        int i;
        ad = {a ? 4'h3 : (f[7] ? 4'hf : 4'h0), f};
        e = m - s;
        wr(4'h0, s);
        if (r) mem[ad] = m;
        issue(r ? {6'h17, d, a, f} : {8'h08, m});
        for (i = 0; i < 20 && instr_done !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        if (i == 20) begin
            mismatches++;
            end_sim;
        end
        @(posedge sys_clk);
        #1 chk("flags", 12'(flags_out), 12'(fl(m, s)));
        chk("acc", 12'(acc_out), 12'((r && d) ? s : e));
        if (r) chk("mem", 12'(mem[ad]), 12'(d ? e : m));
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        for (int a = 0; a < 9; a++) rd(4'(a), 8'h00);
        wr(4'h1, 8'h03);
        rd(4'h1, 8'h03);
        wr(4'h2, 8'h1f);
        rd(4'h2, 8'h1f);
        for (int i = 0; i < 5; i++) begin
            run(1'b0, tm[i], ts[i], tf[i], 1'b0, 1'b0);
            run(1'b1, tm[i], ts[i], tf[i], i[1], i[0]);
        end
        // last run was 8'h7f minus 8'hff from the top access bank at 8'h80
        rd(4'h3, 8'h80);
        rd(4'h4, 8'h80);
        rd(4'h5, 8'h0f);
        issue(16'hffff);
        @(posedge sys_clk);
        rd(4'h7, 8'h01);
        wr(4'h7, 8'h00);
        rd(4'h7, 8'h00);
        end_sim;
    end
endmodule
`default_nettype wire
